// >>> src/aeh_pkg.sv
// Purpose: Shared constants and types for the absolute position handshake
// Assumes: 40 MHz system clock
// Notes: Times are kept in their own units; cycle counts derive from them
package aeh_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 40_000_000;  // System clock rate
    localparam int WAIT_MS = 100;        // Request edge to first character
    localparam int SETTLE_MS = 50;       // Last initial pulse gap to normal output
    localparam int BAUD_BPS = 9600;      // Serial rate
    localparam int WAIT_CYC = CLK_HZ / 1000 * WAIT_MS;
    localparam int SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
    localparam int BIT_CYC = CLK_HZ / BAUD_BPS;  // Clocks per bit, rounded down
    // ==========================================================
    // Message layout
    localparam int MSG_CHARS = 8;            // Characters per message
    localparam int CHAR_W = 7;               // ASCII 7-bit code
    localparam int FRAME_W = 10;             // Start, 7 data, parity, stop
    localparam logic [6:0] CH_HEAD = 7'h50;  // Leading letter
    localparam logic [6:0] CH_PLUS = 7'h2B;
    localparam logic [6:0] CH_MINUS = 7'h2D;
    localparam logic [6:0] CH_ZERO = 7'h30;
    localparam logic [6:0] CH_CR = 7'h0D;
    // ==========================================================
    // Multiturn count
    localparam int TURN_W = 16;
    localparam logic [15:0] TURN_MAX = 16'h7FFF;  // +32767
    localparam logic [15:0] TURN_MIN = 16'h8000;  // -32768
    localparam logic USE_ABSOLUTE = 1'b0;         // Usage select value 0
    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_SEND = 3'b010,
        ST_DRAIN = 3'b011,
        ST_PULSE = 3'b100,
        ST_SETTLE = 3'b101,
        ST_DONE = 3'b110
    } aeh_state_type;
    // Status outputs carried together
    typedef struct packed {
        logic motor_enable;  // Motor may run
        logic servo_ready;   // Ready indication
        logic busy;          // Transmission sequence in progress
        logic setup_lock;    // Setup done, waiting for power cycle
    } aeh_status_type;
endpackage

// >>> src/aeh_top.sv
// Purpose: Absolute position readout handshake with serial message output
// Assumes: Inputs synchronous to clk_i; nrst_i release models power-on
// Notes: Characters pass through a FIFO before the serial transmitter
`timescale 1ns/1ps

// ==========================================================
// FIFO between message builder and transmitter
module aeh_fifo #(
    parameter int WIDTH = 7,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic flush_i,               // Drop all content
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // Storage
    logic [AW:0] wr_ptr;             // Write pointer with wrap bit
    logic [AW:0] rd_ptr;             // Read pointer with wrap bit
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire empty = (wr_ptr == rd_ptr);
    wire full = (wr_ptr[AW] != rd_ptr[AW]) &&
        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    // Pointer update
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end

    // Storage write, no reset needed
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end
endmodule // aeh_fifo

module aeh_top #(
    parameter int WAIT_CYCLES = aeh_pkg::WAIT_CYC,
    parameter int SETTLE_CYCLES = aeh_pkg::SETTLE_CYC,
    parameter int BIT_CYCLES = aeh_pkg::BIT_CYC,
    parameter int PULSE_GAP = 16,           // Cycles between initial pulses
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic absolute_data_request_i,  // Request line level
    input wire logic absolute_usage_select_i,  // 0 absolute, 1 incremental
    input wire logic servo_on_i,               // Servo on command
    input wire logic count_up_i,               // One turn forward
    input wire logic count_down_i,             // One turn backward
    input wire logic [15:0] init_pulses_i,     // Initial pulse count
    input wire logic setup_i,                  // Setup request pulse
    output logic serial_position_output_o,     // Serial line, idle high
    output logic init_pulse_o,                 // Initial pulse train
    output logic setup_reject_o,               // Setup refused pulse
    output logic [15:0] turns_o,               // Multiturn count
    output aeh_pkg::aeh_status_type status_o
);
    // ==========================================================
    // Declarations
    aeh_pkg::aeh_state_type state;      // Sequencer state
    aeh_pkg::aeh_state_type next_state;
    logic [15:0] turns;                 // Signed multiturn count
    logic [31:0] timer;                 // Shared wait counter
    logic [2:0] char_idx;               // Next character to queue
    logic [15:0] pulse_left;            // Initial pulses remaining
    logic req_q;                        // Request of last cycle
    logic usage;                        // Usage latched at power-on
    logic usage_taken;                  // Latch done after release
    logic setup_lock;                   // Awaiting power cycle
    logic tx_busy;                      // Transmitter active
    logic [9:0] tx_sh;                  // Frame shift register
    logic [3:0] tx_bits;                // Bits sent of frame
    logic [31:0] tx_timer;              // Bit time counter
    logic pulse;                        // Pulse output register
    logic reject;                       // Reject output register
    logic fifo_ready, fifo_valid;
    logic [6:0] fifo_data;

    // Character of the message at a position
    function automatic logic [6:0] msg_char(input logic [2:0] idx,
                                            input logic [15:0] cnt);
        logic [16:0] mag;
        logic [16:0] dv;
        mag = cnt[15] ? 17'(-$signed({cnt[15], cnt})) : {1'b0, cnt};
        dv = 17'h00000;
        case (idx)
            3'h2: dv = mag / 17'd10000;
            3'h3: dv = (mag / 17'd1000) % 17'd10;
            3'h4: dv = (mag / 17'd100) % 17'd10;
            3'h5: dv = (mag / 17'd10) % 17'd10;
            3'h6: dv = mag % 17'd10;
            default: dv = 17'h00000;
        endcase
        case (idx)
            3'h0: msg_char = aeh_pkg::CH_HEAD;
            3'h1: msg_char = cnt[15] ? aeh_pkg::CH_MINUS : aeh_pkg::CH_PLUS;
            3'h7: msg_char = aeh_pkg::CH_CR;
            default: msg_char = aeh_pkg::CH_ZERO + 7'(dv);
        endcase
    endfunction

    // ==========================================================
    // Decoding
    wire absolute = (usage == aeh_pkg::USE_ABSOLUTE);
    wire rise = absolute_data_request_i && !req_q;
    wire abort = !absolute_data_request_i && state != aeh_pkg::ST_IDLE
        && state != aeh_pkg::ST_DONE;
    wire push = (state == aeh_pkg::ST_SEND);
    wire pushed = push && fifo_ready;
    wire last_char = (char_idx == 3'(aeh_pkg::MSG_CHARS - 1));
    wire timer_end = (timer == 32'h00000000);
    wire tx_take = fifo_valid && !tx_busy;
    wire bit_end = (tx_timer == 32'(BIT_CYCLES - 1));
    wire seq_done = (state == aeh_pkg::ST_DONE);
    wire motor_enable = servo_on_i && !setup_lock &&
        (!absolute || seq_done);
    wire servo_ready = !setup_lock && (!absolute ||
        (absolute_data_request_i && seq_done));
    wire setup_ok = setup_i && !servo_on_i;
    wire [6:0] par_char = msg_char(char_idx, turns);
    wire par_bit = ^fifo_data;

    assign serial_position_output_o = tx_sh[0];
    assign init_pulse_o = pulse;
    assign setup_reject_o = reject;
    assign turns_o = turns;
    assign status_o = '{motor_enable: motor_enable, servo_ready: servo_ready,
        busy: (state != aeh_pkg::ST_IDLE && !seq_done),
        setup_lock: setup_lock};

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            aeh_pkg::ST_IDLE:
                if (absolute && rise) next_state = aeh_pkg::ST_WAIT;
            aeh_pkg::ST_WAIT:
                if (timer_end) next_state = aeh_pkg::ST_SEND;
            aeh_pkg::ST_SEND:
                if (pushed && last_char) next_state = aeh_pkg::ST_DRAIN;
            aeh_pkg::ST_DRAIN:
                if (!fifo_valid && !tx_busy) next_state = aeh_pkg::ST_PULSE;
            aeh_pkg::ST_PULSE:
                if (pulse_left == 16'h0000 && timer_end) begin
                    next_state = aeh_pkg::ST_SETTLE;
                end
            aeh_pkg::ST_SETTLE:
                if (timer_end) next_state = aeh_pkg::ST_DONE;
            aeh_pkg::ST_DONE:
                if (!absolute_data_request_i) next_state = aeh_pkg::ST_IDLE;
            default: next_state = aeh_pkg::ST_IDLE;
        endcase
        if (abort) next_state = aeh_pkg::ST_IDLE;
    end

    // Sequencer registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= aeh_pkg::ST_IDLE;
            req_q <= 1'b0;
        end else begin
            state <= next_state;
            req_q <= absolute_data_request_i;
        end
    end

    // Wait timer, character index and pulse train
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer <= 32'h00000000;
            char_idx <= 3'h0;
            pulse_left <= 16'h0000;
            pulse <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (next_state != state) begin
                // Load the wait of the state being entered
                case (next_state)
                    aeh_pkg::ST_WAIT: timer <= 32'(WAIT_CYCLES - 1);
                    aeh_pkg::ST_SETTLE: timer <= 32'(SETTLE_CYCLES - 1);
                    default: timer <= 32'(PULSE_GAP - 1);
                endcase
                char_idx <= 3'h0;
                pulse_left <= init_pulses_i;
            end else if (!timer_end) begin
                timer <= timer - 32'h00000001;
            end else if (state == aeh_pkg::ST_PULSE &&
                pulse_left != 16'h0000) begin
                pulse <= 1'b1;
                pulse_left <= pulse_left - 16'h0001;
                timer <= 32'(PULSE_GAP - 1);
            end
            if (pushed) char_idx <= char_idx + 3'h1;
        end
    end

    // Multiturn count, wraps by two's complement arithmetic
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            turns <= 16'h0000;
            reject <= 1'b0;
        end else begin
            reject <= setup_i && servo_on_i;
            if (setup_ok) begin
                turns <= 16'h0000;
            end else if (count_up_i && !count_down_i) begin
                turns <= turns + 16'h0001;
            end else if (count_down_i && !count_up_i) begin
                turns <= turns - 16'h0001;
            end
        end
    end

    // Usage caught once after release; setup locks until next reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            usage <= aeh_pkg::USE_ABSOLUTE;
            usage_taken <= 1'b0;
            setup_lock <= 1'b0;
        end else begin
            if (!usage_taken) usage <= absolute_usage_select_i;
            usage_taken <= 1'b1;
            if (setup_ok) setup_lock <= 1'b1;
        end
    end

    // Serial transmitter, LSB first
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_busy <= 1'b0;
            tx_sh <= 10'h3FF;
            tx_bits <= 4'h0;
            tx_timer <= 32'h00000000;
        end else if (tx_take) begin
            tx_busy <= 1'b1;
            tx_sh <= {1'b1, par_bit, fifo_data, 1'b0};
            tx_bits <= 4'h0;
            tx_timer <= 32'h00000000;
        end else if (tx_busy) begin
            tx_timer <= bit_end ? 32'h00000000 : tx_timer + 32'h00000001;
            if (bit_end) begin
                tx_sh <= {1'b1, tx_sh[9:1]};
                tx_bits <= tx_bits + 4'h1;
                if (tx_bits == 4'(aeh_pkg::FRAME_W - 1)) tx_busy <= 1'b0;
            end
        end
    end

    // Character queue
    aeh_fifo #(.WIDTH(aeh_pkg::CHAR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .flush_i(abort),
        .in_valid_i(push),
        .in_ready_o(fifo_ready),
        .in_data_i(par_char),
        .out_valid_o(fifo_valid),
        .out_ready_i(!tx_busy),
        .out_data_o(fifo_data)
    );

    // ==========================================================
    // Assertions
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wrap_top_a: assert property (
        turns == aeh_pkg::TURN_MAX && count_up_i && !count_down_i &&
        !setup_ok |=> turns == aeh_pkg::TURN_MIN)
        else $error("count did not wrap up");
    wrap_bottom_a: assert property (
        turns == aeh_pkg::TURN_MIN && count_down_i && !count_up_i &&
        !setup_ok |=> turns == aeh_pkg::TURN_MAX)
        else $error("count did not wrap down");
    edge_start_a: assert property (
        state == aeh_pkg::ST_IDLE && absolute && rise |=>
        state == aeh_pkg::ST_WAIT ##1 state == aeh_pkg::ST_WAIT)
        else $error("request edge did not start wait");
    motor_lock_a: assert property (
        status_o.motor_enable |-> !absolute || state == aeh_pkg::ST_DONE)
        else $error("motor enabled before transfer end");
    mode_hold_a: assert property (
        usage_taken |=> $stable(usage))
        else $error("usage changed without power cycle");
    setup_refuse_a: assert property (
        setup_i && servo_on_i |=> setup_reject_o && !$rose(setup_lock))
        else $error("setup not refused with servo on");
    frame_form_a: assert property (
        tx_take |=> tx_sh[0] == 1'b0 && tx_sh[9] && ^tx_sh[8:1] == 1'b0)
        else $error("bad serial frame");
    ready_cond_a: assert property (
        status_o.servo_ready && absolute |->
        absolute_data_request_i && state == aeh_pkg::ST_DONE &&
        !tx_busy && !fifo_valid)
        else $error("ready without data sent");
    abort_seq_a: assert property (
        abort |=> state == aeh_pkg::ST_IDLE && !fifo_valid)
        else $error("request drop did not abort");
    setup_clear_a: assert property (
        setup_ok |=> turns == 16'h0000 && setup_lock)
        else $error("setup did not clear count");
endmodule // aeh_top

// >>> verif/aeh_host_model.sv
// Purpose: Host controller model that requests and reads absolute data
// Assumes: Serial bits last BIT_CYCLES clocks; request driven at edges
// Notes: Waits are scaled down to keep the run short
`timescale 1ns/1ps

module aeh_host_model #(
    parameter int BIT_CYCLES = 4,
    parameter int POWER_WAIT = 4,   // Scaled power-up wait
    parameter int HOLD_MIN = 40,    // Scaled minimum high time
    parameter int LOW_MIN = 8       // Scaled minimum low time
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic serial_i,      // Serial position line
    input wire logic init_pulse_i,  // Initial pulse train
    output logic request_o          // Absolute data request line
);
    int up_cnt = 0;        // Cycles since power-on
    int lvl_cnt = 0;       // Cycles at present request level
    int pulse_cnt = 0;     // Initial pulses since last rise
    int parity_bad = 0;    // Frames with bad parity or stop
    logic req_q = 1'b0;    // Request one cycle back
    logic [6:0] rx_q[$];   // Received characters
    initial request_o = 1'b0;

    // ====
    // Time keeping and pulse counter
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            up_cnt <= 0;
            lvl_cnt <= 0;
        end else begin
            up_cnt <= up_cnt + 1;
            req_q <= request_o;
            lvl_cnt <= (request_o != req_q) ? 0 : lvl_cnt + 1;
            if (request_o && !req_q) begin
                pulse_cnt <= 0;  // Clear initial pulse counter
            end else if (init_pulse_i) begin
                pulse_cnt <= pulse_cnt + 1;
            end
        end
    end

    // ====
    // Raise request after power wait and low time
    task automatic raise_req();
        do @(posedge clk_i);
        while (up_cnt < POWER_WAIT || lvl_cnt < LOW_MIN);
        rx_q.delete();  // Clear received characters
        request_o <= 1'b1;
        @(posedge clk_i);
    endtask

    // Drop request, early only when asked to
    task automatic drop_req(input bit early);
        do @(posedge clk_i);
        while (!early && lvl_cnt < HOLD_MIN);
        request_o <= 1'b0;
        @(posedge clk_i);
    endtask

    // ====
    // Frame receiver: start, 7 data, even parity, stop
    always begin : rx_proc
        logic [7:0] sh;
        @(negedge serial_i);
        if (nrst_i) begin
            repeat (BIT_CYCLES / 2) @(posedge clk_i);
            for (int k = 0; k < 8; k++) begin
                repeat (BIT_CYCLES) @(posedge clk_i);
                sh[k] = serial_i;  // LSB first
            end
            repeat (BIT_CYCLES) @(posedge clk_i);
            if (serial_i !== 1'b1 || ^sh !== 1'b0) parity_bad++;
            rx_q.push_back(sh[6:0]);
        end
    end
endmodule // aeh_host_model

// >>> verif/tb_aeh_top.sv
// Purpose: Self-checking bench for the absolute position handshake
// Assumes: Shortened timing parameters; 40 MHz clock
// Notes: Reset release stands in for power-on
`timescale 1ns/1ps

module tb_aeh_top;
    localparam int BIT_CYC = 4;        // Clocks per serial bit
    localparam int MAX_CYC = 80000;    // Hang ceiling
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic usage_sel = 1'b0;            // 0 absolute, 1 incremental
    logic servo_on = 1'b0;
    logic count_up = 1'b0;
    logic count_down = 1'b0;
    logic [15:0] init_pulses = 16'h0005;
    logic setup = 1'b0;
    logic request;
    logic serial;
    logic init_pulse;
    logic setup_reject;
    logic [15:0] turns;
    aeh_pkg::aeh_status_type status;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;

    aeh_top #(.WAIT_CYCLES(20), .SETTLE_CYCLES(10), .BIT_CYCLES(BIT_CYC),
        .PULSE_GAP(2)) aeh_top_i (
        .clk_i(clk_i), .nrst_i(nrst_i),
        .absolute_data_request_i(request),
        .absolute_usage_select_i(usage_sel), .servo_on_i(servo_on),
        .count_up_i(count_up), .count_down_i(count_down),
        .init_pulses_i(init_pulses), .setup_i(setup),
        .serial_position_output_o(serial), .init_pulse_o(init_pulse),
        .setup_reject_o(setup_reject), .turns_o(turns),
        .status_o(status));

    aeh_host_model #(.BIT_CYCLES(BIT_CYC)) aeh_host_model_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .serial_i(serial),
        .init_pulse_i(init_pulse), .request_o(request));

    // ====
    // Clock and hang guard
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == MAX_CYC) begin
            bad_count++;
            end_of_test();
        end
    end

    // ====
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic check_bit(input string what, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic check_word(input string what, input logic [15:0] e,
        input logic [15:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic power_cycle(input logic usage);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        usage_sel <= usage;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        step(2);
    endtask
    task automatic turn(input logic up, input logic dn, input int n);
        repeat (n) begin
            @(posedge clk_i);
            count_up <= up;
            count_down <= dn;
            @(posedge clk_i);
            count_up <= 1'b0;
            count_down <= 1'b0;
        end
        step(1);
    endtask
    task automatic pulse_setup();
        @(posedge clk_i);
        setup <= 1'b1;
        @(posedge clk_i);
        setup <= 1'b0;
        #1;
    endtask
    // Full request, readout and release for count v
    task automatic run_transfer(input int v);
        int n;
        int a;
        logic [6:0] e[8];
        a = (v < 0) ? -v : v;
        e[0] = 7'h50;
        e[1] = (v < 0) ? 7'h2D : 7'h2B;
        for (int k = 6; k >= 2; k--) begin
            e[k] = 7'h30 + 7'(a % 10);
            a = a / 10;
        end
        e[7] = 7'h0D;
        aeh_host_model_i.raise_req();
        step(1);
        check_bit("busy", 1'b1, status.busy);
        n = 0;
        while (status.servo_ready !== 1'b1 && n < 3000) begin
            check_bit("motor_enable", 1'b0, status.motor_enable);
            step(1);
            n++;
        end
        check_bit("servo_ready", 1'b1, status.servo_ready);
        check_bit("motor_enable", 1'b1, status.motor_enable);
        check_word("chars", 16'h0008, 16'(aeh_host_model_i.rx_q.size()));
        for (int k = 0; k < 8; k++) begin
            check_word("char", {9'h000, e[k]},
                {9'h000, aeh_host_model_i.rx_q[k]});
        end
        check_word("parity", 16'h0000, 16'(aeh_host_model_i.parity_bad));
        check_word("pulses", init_pulses, 16'(aeh_host_model_i.pulse_cnt));
        aeh_host_model_i.drop_req(1'b0);
        step(1);
        check_bit("servo_ready", 1'b0, status.servo_ready);
    endtask

    // ====
    // Scenarios
    task automatic test_reset();
        check_bit("serial", 1'b1, serial);
        check_word("turns", 16'h0000, turns);
        check_bit("servo_ready", 1'b0, status.servo_ready);
        check_bit("busy", 1'b0, status.busy);
        $display("test reset done");
    endtask
    task automatic test_transfer();
        @(posedge clk_i);
        servo_on <= 1'b1;
        turn(1'b1, 1'b0, 3);
        check_word("turns", 16'h0003, turns);
        run_transfer(3);
        $display("test transfer done");
    endtask
    task automatic test_abort();
        aeh_host_model_i.raise_req();
        step(5);
        aeh_host_model_i.drop_req(1'b1);
        step(2);
        check_bit("busy", 1'b0, status.busy);
        step(60);
        check_word("chars", 16'h0000, 16'(aeh_host_model_i.rx_q.size()));
        run_transfer(3);
        $display("test abort done");
    endtask
    task automatic test_setup_reject();
        pulse_setup();
        check_bit("setup_reject", 1'b1, setup_reject);
        step(1);
        check_bit("setup_reject", 1'b0, setup_reject);
        check_word("turns", 16'h0003, turns);
        $display("test setup reject done");
    endtask
    task automatic test_wrap();
        turn(1'b0, 1'b1, 32771);
        check_word("turns", 16'h8000, turns);
        turn(1'b0, 1'b1, 1);
        check_word("turns", 16'h7FFF, turns);
        turn(1'b1, 1'b0, 1);
        check_word("turns", 16'h8000, turns);
        turn(1'b1, 1'b1, 1);
        check_word("turns", 16'h8000, turns);
        @(posedge clk_i);
        init_pulses <= 16'h0003;
        run_transfer(-32768);
        $display("test wrap done");
    endtask
    task automatic test_setup();
        @(posedge clk_i);
        servo_on <= 1'b0;
        pulse_setup();
        check_bit("setup_reject", 1'b0, setup_reject);
        check_word("turns", 16'h0000, turns);
        check_bit("setup_lock", 1'b1, status.setup_lock);
        @(posedge clk_i);
        servo_on <= 1'b1;
        step(1);
        check_bit("motor_enable", 1'b0, status.motor_enable);
        $display("test setup done");
    endtask
    task automatic test_usage();
        power_cycle(1'b1);
        check_bit("setup_lock", 1'b0, status.setup_lock);
        check_bit("servo_ready", 1'b1, status.servo_ready);
        check_bit("motor_enable", 1'b1, status.motor_enable);
        aeh_host_model_i.raise_req();
        step(3);
        check_bit("busy", 1'b0, status.busy);
        @(posedge clk_i);
        usage_sel <= 1'b0;
        step(2);
        check_bit("servo_ready", 1'b1, status.servo_ready);
        aeh_host_model_i.drop_req(1'b0);
        power_cycle(1'b0);
        check_bit("servo_ready", 1'b0, status.servo_ready);
        $display("test usage done");
    endtask

    // ====
    // Verdict
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        power_cycle(1'b0);
        test_reset();
        test_transfer();
        test_abort();
        test_setup_reject();
        test_wrap();
        test_setup();
        test_usage();
        end_of_test();
    end
endmodule // tb_aeh_top
